// file: core/hlrc_pkg.sv
// shared constants for the host loadable readable counter block
package hlrc_pkg;

  // byte lane width of the host port and of the counter
  localparam int unsigned HLRC_DATA_W = 8;

  //////////////////////////////////////////////////////////////////////////
  // register byte offsets on the avalon slave
  localparam logic [3:0] HLRC_OFS_CTRL = 4'h0;
  localparam logic [3:0] HLRC_OFS_COUNT = 4'h4;
  localparam logic [3:0] HLRC_OFS_HELD = 4'h8;
  localparam logic [3:0] HLRC_OFS_INREG = 4'hC;

  //////////////////////////////////////////////////////////////////////////
  // control register field positions
  localparam int unsigned HLRC_CTRL_A_LATCH = 0;
  localparam int unsigned HLRC_CTRL_A_PINS = 1;
  localparam int unsigned HLRC_CTRL_B_LATCH = 2;
  localparam int unsigned HLRC_CTRL_B_PINS = 3;
  localparam int unsigned HLRC_CTRL_HOLD_PINS = 4;
  localparam int unsigned HLRC_CTRL_W = 5;

  //////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [HLRC_CTRL_W-1:0] HLRC_CTRL_RST = 5'h00;
  localparam logic [HLRC_DATA_W-1:0] HLRC_DATA_RST = 8'h00;
  localparam logic [31:0] HLRC_RDATA_RST = 32'h00000000;

endpackage : hlrc_pkg

// file: core/hlrc_cnt_if.sv
// control and value signals between the top and the counter
`timescale 1ns/100ps
`default_nettype none
interface hlrc_cnt_if #(parameter int unsigned W = 8);
  logic step;
  logic load;
  logic up;
  logic [W-1:0] preset;
  logic [W-1:0] count;

  modport ctl (output step, output load, output up, output preset,
               input count);
  modport cnt (input step, input load, input up, input preset,
               output count);
endinterface : hlrc_cnt_if
`default_nettype wire

// file: core/hlrc_counter.sv
// loadable up/down counter stepped by the count clock edge
`timescale 1ns/100ps
`default_nettype none
module hlrc_counter
  import hlrc_pkg::*;
#(
  parameter int unsigned W = HLRC_DATA_W
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  hlrc_cnt_if.cnt cnt
);

  logic [W-1:0] count_r;

  if (W < 1)
  begin : g_bad_width
    $error("hlrc_counter: W must be at least 1");
  end

  // preset wins over counting on a count clock edge
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      count_r <= W'(HLRC_DATA_RST);
    else if (cnt.step && cnt.load)
      count_r <= cnt.preset;
    else if (cnt.step && cnt.up)
      count_r <= count_r + W'(1);
    else if (cnt.step)
      count_r <= count_r - W'(1);
  end

  assign cnt.count = count_r;

  //////////////////////////////////////////////////////////////////////////
  // checks on the counter
  a_preset_load: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    cnt.step && cnt.load |=> count_r == $past(cnt.preset))
    else $error("preset not loaded on count edge");

  a_step_up: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    cnt.step && !cnt.load && cnt.up |=> count_r == $past(count_r) + W'(1))
    else $error("counter did not step up by one");

  a_step_down: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    cnt.step && !cnt.load && !cnt.up
      |=> count_r == $past(count_r) - W'(1))
    else $error("counter did not step down by one");

  a_idle_hold: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    !cnt.step |=> $stable(count_r))
    else $error("counter moved without a count edge");

endmodule : hlrc_counter
`default_nettype wire

// file: core/hlrc_in_reg.sv
// byte input register, edge or flow-through, bus or pin sourced
`timescale 1ns/100ps
`default_nettype none
module hlrc_in_reg
  import hlrc_pkg::*;
#(
  parameter int unsigned W = HLRC_DATA_W
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic latch_mode_i,
  input wire logic src_pins_i,
  input wire logic [W-1:0] bus_i,
  input wire logic [W-1:0] pins_i,
  input wire logic strobe_low_i,
  input wire logic strobe_fall_i,
  input wire logic write_enable_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] src;
  logic [W-1:0] q_r;

  if (W < 1)
  begin : g_bad_width
    $error("hlrc_in_reg: W must be at least 1");
  end

  // data source select
  assign src = src_pins_i ? pins_i : bus_i;

  // latch mode flows while strobe low, edge mode takes the strobe edge
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      q_r <= W'(HLRC_DATA_RST);
    else if (write_enable_i && latch_mode_i && strobe_low_i)
      q_r <= src;
    else if (write_enable_i && !latch_mode_i && strobe_fall_i)
      q_r <= src;
  end

  assign q_o = q_r;

  //////////////////////////////////////////////////////////////////////////
  // checks on the input register
  a_we_gates_capture: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    !write_enable_i |=> $stable(q_r))
    else $error("input register changed with write enable low");

  a_edge_capture: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    write_enable_i && !latch_mode_i && strobe_fall_i |=> q_r == $past(src))
    else $error("edge mode missed the strobe");

  a_edge_holds: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    !latch_mode_i && !strobe_fall_i |=> $stable(q_r))
    else $error("edge mode register moved between strobes");

endmodule : hlrc_in_reg
`default_nettype wire

// file: core/hlrc_top.sv
// host loadable readable counter with byte host port and avalon slave
//
// How it works
// - eight-bit up/down counter, host presets and reads
// - preset loads when request low at count edge
// - write strobe captures preset into input register
// - host data crosses transceiver onto internal bus
// - input registers selectable edge or flow-through
// - input data from pins or internal bus
// - input register feeds logic on same side
// - read logic gathered as byte into holding latch
// - holding latch flows with enable and clock high
// - held value drives bus while read enabled
// - host bus driven with port enable, strobe low
// - strobe high turns transceiver inward again
// - extra output port from input latch outputs
// - extra input port through holding latch
// - holding latch keeps value after clock falls
// - host port undriven while port enable low
// - input register captures only with write enable
`timescale 1ns/100ps
`default_nettype none
module hlrc_top
  import hlrc_pkg::*;
#(
  parameter int unsigned W = HLRC_DATA_W
)
(
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // avalon-mm slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // host byte port, split two-way pins
  input wire logic [W-1:0] host_data_i,
  output logic [W-1:0] host_data_o,
  output logic host_data_oe_o,
  input wire logic host_write_strobe_n_i,
  input wire logic host_read_strobe_n_i,
  input wire logic write_enable_i,
  input wire logic read_enable_i,
  input wire logic port_enable_i,
  // holding latch controls
  input wire logic holding_latch_enable_i,
  input wire logic system_latch_clock_i,
  // counter controls
  input wire logic count_clock_i,
  input wire logic preset_request_low_n_i,
  input wire logic count_up_i,
  // general pins and extra ports
  input wire logic [W-1:0] gp_pins_i,
  input wire logic [W-1:0] extra_input_port_i,
  output logic [W-1:0] extra_output_port_o
);

  if (W < 1 || W > 16)
  begin : g_bad_width
    $error("hlrc_top: W must lie between 1 and 16");
  end

  localparam int unsigned CTL_N = 10;
  localparam int unsigned SYNC_W = CTL_N + 3 * W;

  //////////////////////////////////////////////////////////////////////////
  // reset release through two flip-flops
  logic rst_meta_r;
  logic rst_n;

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers, stage three only for edge detection
  logic [SYNC_W-1:0] async_in;
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic [1:0] sync3_r;

  assign async_in = {extra_input_port_i, gp_pins_i, host_data_i,
                     ~host_write_strobe_n_i, ~host_read_strobe_n_i,
                     write_enable_i, read_enable_i, port_enable_i,
                     holding_latch_enable_i, system_latch_clock_i,
                     count_clock_i, ~preset_request_low_n_i, count_up_i};

  // two-stage capture of every pin
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
    end
    else
    begin
      sync1_r <= async_in;
      sync2_r <= sync1_r;
      sync3_r <= {sync2_r[9], sync2_r[2]};
    end
  end

  logic wr_low_s;
  logic rd_low_s;
  logic we_s;
  logic re_s;
  logic port_en_s;
  logic hle_s;
  logic lclk_s;
  logic cclk_s;
  logic preset_req_s;
  logic up_s;
  logic [W-1:0] host_data_s;
  logic [W-1:0] gp_pins_s;
  logic [W-1:0] ext_in_s;
  logic wr_fall;
  logic cclk_rise;

  // named views of the synchronised pins
  assign wr_low_s = sync2_r[9];
  assign rd_low_s = sync2_r[8];
  assign we_s = sync2_r[7];
  assign re_s = sync2_r[6];
  assign port_en_s = sync2_r[5];
  assign hle_s = sync2_r[4];
  assign lclk_s = sync2_r[3];
  assign cclk_s = sync2_r[2];
  assign preset_req_s = sync2_r[1];
  assign up_s = sync2_r[0];
  assign host_data_s = sync2_r[CTL_N +: W];
  assign gp_pins_s = sync2_r[CTL_N + W +: W];
  assign ext_in_s = sync2_r[CTL_N + 2 * W +: W];
  // strobe assertion and count clock rising edge
  assign wr_fall = wr_low_s & ~sync3_r[1];
  assign cclk_rise = cclk_s & ~sync3_r[0];
  //////////////////////////////////////////////////////////////////////////
  // control register and avalon slave state
  logic [HLRC_CTRL_W-1:0] ctrl_r;
  logic wait_r;
  logic [31:0] rdata_r;
  logic [W-1:0] held_r;
  logic [W-1:0] in_a;
  logic [W-1:0] in_b;
  logic [W-1:0] ibus;
  logic [W-1:0] hold_src;
  hlrc_cnt_if #(.W(W)) cnt_if ();

  //////////////////////////////////////////////////////////////////////////
  // internal bus: held value when reading with read enable, host data while read strobe high, zero otherwise
  always_comb
  begin
    if (rd_low_s && re_s)
      ibus = held_r;
    else if (!rd_low_s)
      ibus = host_data_s;
    else
      ibus = W'(HLRC_DATA_RST);
  end

  //////////////////////////////////////////////////////////////////////////
  // input register a feeds the counter preset on its side
  hlrc_in_reg #(.W(W)) u_in_a (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .latch_mode_i(ctrl_r[HLRC_CTRL_A_LATCH]),
    .src_pins_i(ctrl_r[HLRC_CTRL_A_PINS]),
    .bus_i(ibus),
    .pins_i(gp_pins_s),
    .strobe_low_i(wr_low_s),
    .strobe_fall_i(wr_fall),
    .write_enable_i(we_s),
    .q_o(in_a)
  );

  // input register b feeds the extra output port on its side
  hlrc_in_reg #(.W(W)) u_in_b (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .latch_mode_i(ctrl_r[HLRC_CTRL_B_LATCH]),
    .src_pins_i(ctrl_r[HLRC_CTRL_B_PINS]),
    .bus_i(ibus),
    .pins_i(gp_pins_s),
    .strobe_low_i(wr_low_s),
    .strobe_fall_i(wr_fall),
    .write_enable_i(we_s),
    .q_o(in_b)
  );

  //////////////////////////////////////////////////////////////////////////
  // counter hookup; the host keeps the count edge after the strobe
  assign cnt_if.step = cclk_rise;
  assign cnt_if.load = preset_req_s;
  assign cnt_if.up = up_s;
  assign cnt_if.preset = in_a;

  hlrc_counter #(.W(W)) u_counter (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .cnt(cnt_if.cnt)
  );

  //////////////////////////////////////////////////////////////////////////
  // holding latch source: counter byte or extra input port
  assign hold_src = ctrl_r[HLRC_CTRL_HOLD_PINS] ? ext_in_s
                                                : cnt_if.count;
  // flow while enable and latch clock high, hold once clock falls
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      held_r <= W'(HLRC_DATA_RST);
    else if (hle_s && lclk_s)
      held_r <= hold_src;
  end

  //////////////////////////////////////////////////////////////////////////
  // host port drive, undriven unless enabled and read strobe low
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      host_data_oe_o <= 1'b0;
      host_data_o <= W'(HLRC_DATA_RST);
    end
    else
    begin
      host_data_oe_o <= port_en_s && rd_low_s;
      host_data_o <= ibus;
    end
  end

  // extra output port from input register b
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      extra_output_port_o <= W'(HLRC_DATA_RST);
    else
      extra_output_port_o <= in_b;
  end

  //////////////////////////////////////////////////////////////////////////
  // avalon waitrequest: low for one cycle per request
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      wait_r <= 1'b1;
    else if (wait_r && (avs_read_i || avs_write_i))
      wait_r <= 1'b0;
    else
      wait_r <= 1'b1;
  end

  // read data prepared while waitrequest still high
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      rdata_r <= HLRC_RDATA_RST;
    else if (wait_r && avs_read_i)
    begin
      case (avs_address_i)
        HLRC_OFS_CTRL: rdata_r <= 32'(ctrl_r);
        HLRC_OFS_COUNT: rdata_r <= 32'(cnt_if.count);
        HLRC_OFS_HELD: rdata_r <= 32'(held_r);
        HLRC_OFS_INREG: rdata_r <= 32'({in_b, in_a});
        default: rdata_r <= HLRC_RDATA_RST;
      endcase
    end
  end

  // control write takes effect at the edge waitrequest is low
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_r <= HLRC_CTRL_RST;
    else if (avs_write_i && !wait_r && avs_address_i == HLRC_OFS_CTRL
             && avs_byteenable_i[0])
      ctrl_r <= avs_writedata_i[HLRC_CTRL_W-1:0];
  end

  assign avs_waitrequest_o = wait_r;
  assign avs_readdata_o = rdata_r;

  //////////////////////////////////////////////////////////////////////////
  // checks on the host port, latch and slave
  a_port_turnaround: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    !rd_low_s |=> !host_data_oe_o)
    else $error("transceiver still outward after read strobe high");
  a_port_undriven: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    !port_en_s |=> !host_data_oe_o)
    else $error("host port driven with port enable low");
  a_read_drive: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    port_en_s && rd_low_s && re_s
      |=> host_data_oe_o && host_data_o == $past(held_r))
    else $error("host read did not drive the held value");
  a_latch_flow: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    hle_s && lclk_s && !ctrl_r[HLRC_CTRL_HOLD_PINS]
      |=> held_r == $past(cnt_if.count))
    else $error("holding latch not flowing the count");
  a_latch_holds: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    !(hle_s && lclk_s) |=> $stable(held_r))
    else $error("holding latch changed while closed");
  a_ext_out_follows: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    ##1 extra_output_port_o == $past(in_b))
    else $error("extra output port lags its register");
  a_wait_one_cycle: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    (avs_read_i || avs_write_i) && wait_r |=> !wait_r ##1 wait_r)
    else $error("waitrequest not low for exactly one cycle");
  a_ctrl_written: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    avs_write_i && !wait_r && avs_address_i == HLRC_OFS_CTRL
      && avs_byteenable_i[0]
      |=> ctrl_r == $past(avs_writedata_i[HLRC_CTRL_W-1:0]))
    else $error("control write lost");
endmodule : hlrc_top
`default_nettype wire

// file: dv/hlrc_host_model.sv
// host processor model driving the byte port strobes, data and count clock
`timescale 1ns/100ps
`default_nettype none
module hlrc_host_model
  import hlrc_pkg::*;
(
  input wire logic clk_i,
  input wire logic [HLRC_DATA_W-1:0] dev_data_i,
  input wire logic dev_oe_i,
  output logic [HLRC_DATA_W-1:0] bus_o,
  output logic ws_n_o,
  output logic rs_n_o,
  output logic write_enable_o,
  output logic read_enable_o,
  output logic port_enable_o,
  output logic count_clock_o,
  output logic preset_n_o,
  output logic count_up_o
);
  logic [HLRC_DATA_W-1:0] drv = '0;
  logic [HLRC_DATA_W-1:0] last = '0;
  logic drv_en = 1'b0;

  // resolved bus level; an undriven bus toggles every cycle
  assign bus_o = dev_oe_i ? dev_data_i : (drv_en ? drv : ~last);
  always @(posedge clk_i) last <= bus_o;

  // idle levels at time zero
  initial
  begin
    ws_n_o = 1'b1;
    rs_n_o = 1'b1;
    write_enable_o = 1'b0;
    read_enable_o = 1'b0;
    port_enable_o = 1'b0;
    count_clock_o = 1'b0;
    preset_n_o = 1'b1;
    count_up_o = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // each phase lasts four cycles, above the three the sync path needs
  task automatic wait4();
    repeat (4) @(posedge clk_i);
  endtask : wait4

  // data goes out only once the read strobe is back high
  task automatic put(input logic [HLRC_DATA_W-1:0] v);
    rs_n_o <= 1'b1;
    drv <= v;
    drv_en <= 1'b1;
    wait4();
  endtask : put

  task automatic low(input logic we);
    write_enable_o <= we;
    ws_n_o <= 1'b0;
    wait4();
  endtask : low

  task automatic high();
    ws_n_o <= 1'b1;
    wait4();
  endtask : high

  task automatic strobe(input logic we);
    low(we);
    high();
  endtask : strobe

  // count edge comes well after the last write strobe
  task automatic step(input logic pre_n, input logic up);
    preset_n_o <= pre_n;
    count_up_o <= up;
    wait4();
    count_clock_o <= 1'b1;
    wait4();
    count_clock_o <= 1'b0;
    preset_n_o <= 1'b1;
    wait4();
  endtask : step

  // host releases its data in the same step that asks the device to drive
  task automatic rd_on(input logic re, input logic pe);
    drv_en <= 1'b0;
    read_enable_o <= re;
    port_enable_o <= pe;
    rs_n_o <= 1'b0;
    wait4();
  endtask : rd_on

  task automatic rd_off();
    rs_n_o <= 1'b1;
    wait4();
  endtask : rd_off
endmodule : hlrc_host_model
`default_nettype wire

// file: dv/hlrc_top_tb.sv
// self-checking testbench for the host loadable readable counter
`timescale 1ns/100ps
`default_nettype none
module hlrc_top_tb
  import hlrc_pkg::*;
;
  logic ref_clk, arst_n, av_rd, av_wr, av_wait, oe, hle, lclk;
  logic ws_n, rs_n, we, re, pe, cclk, pre_n, up;
  logic [3:0] av_adr, av_be;
  logic [31:0] av_wd, av_rdata, rnd;
  logic [7:0] hd_in, hd_out, gp, xin, xout, v, c, h, e;
  logic [31:0] exp_q[$];
  int fail_count, samples_checked, cycles;

  hlrc_top hlrc_top_inst (.ref_clk_i(ref_clk), .arst_n_i(arst_n),
    .avs_address_i(av_adr), .avs_read_i(av_rd), .avs_write_i(av_wr),
    .avs_byteenable_i(av_be), .avs_writedata_i(av_wd),
    .avs_readdata_o(av_rdata), .avs_waitrequest_o(av_wait),
    .host_data_i(hd_in), .host_data_o(hd_out), .host_data_oe_o(oe),
    .host_write_strobe_n_i(ws_n), .host_read_strobe_n_i(rs_n),
    .write_enable_i(we), .read_enable_i(re), .port_enable_i(pe),
    .holding_latch_enable_i(hle), .system_latch_clock_i(lclk),
    .count_clock_i(cclk), .preset_request_low_n_i(pre_n),
    .count_up_i(up), .gp_pins_i(gp), .extra_input_port_i(xin),
    .extra_output_port_o(xout));

  hlrc_host_model hlrc_host_model_inst (.clk_i(ref_clk),
    .dev_data_i(hd_out), .dev_oe_i(oe), .bus_o(hd_in), .ws_n_o(ws_n),
    .rs_n_o(rs_n), .write_enable_o(we), .read_enable_o(re),
    .port_enable_o(pe), .count_clock_o(cclk), .preset_n_o(pre_n),
    .count_up_o(up));

  // 25 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic finish_test();
    if (fail_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] sn);
    samples_checked++;
    if (sn !== ex)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, ex, sn);
    end
  endtask : chk

  // watchdog against a hung handshake
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      finish_test();
    end
  end

  // read data taken at the edge where waitrequest is seen low
  always @(posedge ref_clk)
    if (av_rd === 1'b1 && av_wait === 1'b0)
      chk("avs_readdata_o", exp_q.pop_front(), av_rdata);

  ////////////////////////////////////////////////////////////////////////////
  // avalon master cycles: hold until waitrequest low, release after
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input logic [3:0] b);
    av_adr <= a;
    av_wd <= d;
    av_be <= b;
    av_wr <= 1'b1;
    do @(posedge ref_clk); while (av_wait !== 1'b0);
    av_wr <= 1'b0;
    @(posedge ref_clk);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] ex);
    exp_q.push_back(ex);
    av_adr <= a;
    av_rd <= 1'b1;
    do @(posedge ref_clk); while (av_wait !== 1'b0);
    av_rd <= 1'b0;
    @(posedge ref_clk);
  endtask : rd

  // pulse the system latch clock with the given latch enable
  task automatic latch(input logic en);
    hle <= en;
    lclk <= 1'b1;
    repeat (4) @(posedge ref_clk);
    lclk <= 1'b0;
    repeat (4) @(posedge ref_clk);
    hle <= 1'b0;
  endtask : latch

  // main sequence
  initial
  begin
    fail_count = 0;
    samples_checked = 0;
    cycles = 0;
    arst_n = 1'b0;
    {av_rd, av_wr, hle, lclk} = 4'h0;
    av_adr = 4'h0;
    av_be = 4'hF;
    av_wd = 32'h0;
    gp = 8'h00;
    xin = 8'h00;
    rnd = $urandom(25640);
    v = rnd[7:0];
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    // reset values and refused accesses
    rd(HLRC_OFS_CTRL, 32'h0);
    rd(4'h2, 32'h0);
    wr(HLRC_OFS_CTRL, 32'h1F, 4'hE);
    wr(HLRC_OFS_COUNT, 32'h5A, 4'hF);
    rd(HLRC_OFS_CTRL, 32'h0);
    rd(HLRC_OFS_COUNT, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      rnd = $urandom;
      wr(HLRC_OFS_CTRL, {27'h0, rnd[4:0]}, 4'h1);
      rd(HLRC_OFS_CTRL, {27'h0, rnd[4:0]});
    end
    wr(HLRC_OFS_CTRL, 32'h0, 4'h1);
    // host write from the bus, then one refused by write enable low
    hlrc_host_model_inst.put(v);
    hlrc_host_model_inst.strobe(1'b1);
    rd(HLRC_OFS_INREG, {16'h0, v, v});
    chk("extra_output_port_o", {24'h0, v}, {24'h0, xout});
    hlrc_host_model_inst.put(~v);
    hlrc_host_model_inst.strobe(1'b0);
    rd(HLRC_OFS_INREG, {16'h0, v, v});
    // preset and random up/down steps
    hlrc_host_model_inst.step(1'b0, 1'b1);
    c = v;
    rd(HLRC_OFS_COUNT, {24'h0, c});
    for (int i = 0; i < 6; i++)
    begin
      rnd = $urandom;
      hlrc_host_model_inst.step(1'b1, rnd[0]);
      c = rnd[0] ? c + 8'h01 : c - 8'h01;
      rd(HLRC_OFS_COUNT, {24'h0, c});
    end
    // wrap at both ends of the count
    hlrc_host_model_inst.put(8'hFF);
    hlrc_host_model_inst.strobe(1'b1);
    hlrc_host_model_inst.step(1'b0, 1'b0);
    hlrc_host_model_inst.step(1'b1, 1'b1);
    rd(HLRC_OFS_COUNT, 32'h0);
    hlrc_host_model_inst.step(1'b1, 1'b0);
    c = 8'hFF;
    rd(HLRC_OFS_COUNT, {24'h0, c});
    // holding latch flows, then holds
    latch(1'b1);
    h = c;
    rd(HLRC_OFS_HELD, {24'h0, h});
    hlrc_host_model_inst.step(1'b1, 1'b1);
    rd(HLRC_OFS_HELD, {24'h0, h});
    latch(1'b0);
    rd(HLRC_OFS_HELD, {24'h0, h});
    // host read through the transceiver
    hlrc_host_model_inst.rd_on(1'b1, 1'b1);
    chk("host_data_oe_o", 32'h1, {31'h0, oe});
    chk("host_data_o", {24'h0, h}, {24'h0, hd_out});
    hlrc_host_model_inst.rd_on(1'b0, 1'b1);
    chk("host_data_o", 32'h0, {24'h0, hd_out});
    hlrc_host_model_inst.rd_on(1'b1, 1'b0);
    chk("host_data_oe_o", 32'h0, {31'h0, oe});
    hlrc_host_model_inst.rd_on(1'b1, 1'b1);
    hlrc_host_model_inst.rd_off();
    chk("host_data_oe_o", 32'h0, {31'h0, oe});
    // extra input port through the holding latch
    rnd = $urandom;
    xin <= rnd[15:8];
    wr(HLRC_OFS_CTRL, 32'h10, 4'h1);
    latch(1'b1);
    rd(HLRC_OFS_HELD, {24'h0, rnd[15:8]});
    // pin source, edge mode then flow-through mode
    for (int m = 0; m < 2; m++)
    begin
      rnd = $urandom;
      gp <= rnd[7:0];
      wr(HLRC_OFS_CTRL, (m == 1) ? 32'h0F : 32'h0A, 4'h1);
      hlrc_host_model_inst.low(1'b1);
      gp <= rnd[15:8];
      repeat (4) @(posedge ref_clk);
      hlrc_host_model_inst.high();
      e = (m == 1) ? rnd[15:8] : rnd[7:0];
      rd(HLRC_OFS_INREG, {16'h0, e, e});
      chk("extra_output_port_o", {24'h0, e}, {24'h0, xout});
    end
    finish_test();
  end
endmodule : hlrc_top_tb
`default_nettype wire
